// ===== logic/mccd_pkg.sv
// constants and types shared by the instruction execution block
package mccd_pkg;
  // instruction word is 14 bits wide
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int WDOG_W = 8;
  localparam int PRE_W = 8;
  // encodings of the supported operations
  localparam logic [13:0] OPC_WD_CLEAR_WORD = 14'h0064;
  localparam logic [13:0] OPC_ACC_CLEAR_WORD = 14'h0100;
  localparam logic [6:0] OPC_REG_CLEAR_HI = 7'h03;
  localparam logic [5:0] OPC_REG_COMPL_HI = 6'h09;
  localparam logic [5:0] OPC_REG_DEC_HI = 6'h03;
  localparam logic [2:0] OPC_CALL_HI = 3'h4;
  // field positions inside the instruction word
  localparam int DEST_BIT = 7;
  localparam int FADDR_LSB = 0;
  localparam int IMM_W = 11;
  // pc high latch bits copied into pc bits 12:11
  localparam int PCH_LO = 3;
  localparam int PCH_HI = 4;
  // reset values and datapath constants
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRE_CLEAR = 8'h00;
  localparam logic [12:0] PC_ONE = 13'h0001;
  // cycles taken by the subroutine jump
  localparam int CALL_CYCLES = 2;

  typedef enum logic [2:0] {
    MCCD_OP_NONE,
    MCCD_OP_WDOG_CLR,
    MCCD_OP_CALL,
    MCCD_OP_COMPL,
    MCCD_OP_REG_CLR,
    MCCD_OP_DEC,
    MCCD_OP_ACC_CLR
  } mccd_op_t;
endpackage

// ===== logic/mccd_decode.sv
// instruction word decoder for the execution block
`timescale 1ns/1ps
module mccd_decode (
  // instruction
  input wire logic [13:0] insn_in,
  // decoded fields
  output mccd_pkg::mccd_op_t op_out,
  output logic [6:0] faddr_out,
  output logic dest_out,
  output logic [10:0] imm_out
);
  // ***************************************************
  // field extraction
  // ***************************************************
  assign faddr_out = insn_in[6:0];
  assign dest_out = insn_in[mccd_pkg::DEST_BIT];
  assign imm_out = insn_in[10:0];

  wire is_wclr = insn_in == mccd_pkg::OPC_WD_CLEAR_WORD;
  wire is_aclr = insn_in[13:7] == mccd_pkg::OPC_ACC_CLEAR_WORD[13:7];
  wire is_rclr = insn_in[13:7] == mccd_pkg::OPC_REG_CLEAR_HI;
  wire is_compl = insn_in[13:8] == mccd_pkg::OPC_REG_COMPL_HI;
  wire is_dec = insn_in[13:8] == mccd_pkg::OPC_REG_DEC_HI;
  wire is_call = insn_in[13:11] == mccd_pkg::OPC_CALL_HI;

  always_comb begin
    if (is_wclr) begin
      op_out = mccd_pkg::MCCD_OP_WDOG_CLR;
    end else if (is_call) begin
      op_out = mccd_pkg::MCCD_OP_CALL;
    end else if (is_compl) begin
      op_out = mccd_pkg::MCCD_OP_COMPL;
    end else if (is_dec) begin
      op_out = mccd_pkg::MCCD_OP_DEC;
    end else if (is_rclr) begin
      op_out = mccd_pkg::MCCD_OP_REG_CLR;
    end else if (is_aclr) begin
      op_out = mccd_pkg::MCCD_OP_ACC_CLR;
    end else begin
      op_out = mccd_pkg::MCCD_OP_NONE;
    end
  end
endmodule

// ===== logic/mccd_exec.sv
// execution of watchdog clear, call, complement, clear and decrement
//
// Behaviour
// - watchdog clear zeroes watchdog counter
// - watchdog clear zeroes watchdog prescaler
// - watchdog clear sets timeout and powerdown flags
// - call pushes pc plus one onto stack
// - call loads 11-bit immediate into pc
// - call takes pc 12:11 from latch 4:3
// - call takes two cycles, flags untouched
// - complement result goes to accumulator or register
// - clear register writes zero, sets zero flag
// - decrement result goes to accumulator or register
// - clear accumulator zeroes it, sets zero flag
`timescale 1ns/1ps
module mccd_exec (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // instruction stream
  input wire logic INSN_VALID_IN,
  input wire logic [13:0] INSN_IN,
  // file register read data for the addressed register
  input wire logic [7:0] FREG_RDATA_IN,
  // pc high latch contents
  input wire logic [7:0] PC_HIGH_LATCH_IN,
  // program counter and stack
  output logic [12:0] PC_OUT,
  output logic STACK_PUSH_OUT,
  output logic [12:0] RETURN_STACK_TOP_OUT,
  // file register write port
  output logic [6:0] FREG_ADDR_OUT,
  output logic FREG_WE_OUT,
  output logic [7:0] FREG_WDATA_OUT,
  // accumulator and status
  output logic [7:0] ACCUM_OUT,
  output logic ZERO_FLAG_OUT,
  output logic TIMEOUT_FLAG_OUT,
  output logic POWERDOWN_FLAG_OUT,
  // watchdog
  output logic [7:0] WATCHDOG_COUNTER_OUT,
  output logic [7:0] WATCHDOG_PRESCALER_OUT,
  // handshake: low during the second cycle of a call
  output logic INSN_READY_OUT
);
  // ***************************************************
  // decode
  // ***************************************************
  mccd_pkg::mccd_op_t op;
  logic [6:0] faddr;
  logic dest;
  logic [10:0] imm;

  mccd_decode u_decode (
    .insn_in(INSN_IN),
    .op_out(op),
    .faddr_out(faddr),
    .dest_out(dest),
    .imm_out(imm)
  );

  logic [12:0] pc_q, pc_d;
  logic [7:0] w_q, w_d;
  logic z_q, z_d;
  logic tmo_q, tmo_d;
  logic pdn_q, pdn_d;
  logic [7:0] wdog_q, wdog_d;
  logic [7:0] pre_q, pre_d;
  logic [12:0] ret_q, ret_d;
  logic push_q, push_d;
  logic fwe_q, fwe_d;
  logic [6:0] fa_q, fa_d;
  logic [7:0] fwd_q, fwd_d;
  logic busy_q, busy_d;

  // a call occupies a second, idle cycle; the word offered then is ignored
  wire take = INSN_VALID_IN && !busy_q;
  wire do_op = take;

  // ***************************************************
  // datapath
  // ***************************************************
  wire [7:0] comp_res = ~FREG_RDATA_IN;
  wire [7:0] dec_res = FREG_RDATA_IN - mccd_pkg::ONE8;
  // only complement and decrement reach the result mux, so one select will do
  wire is_compl = op == mccd_pkg::MCCD_OP_COMPL;
  wire [7:0] alu_res = is_compl ? comp_res : dec_res;
  wire res_zero = alu_res == mccd_pkg::ZERO8;
  wire [12:0] pc_inc = pc_q + mccd_pkg::PC_ONE;
  wire [12:0] call_tgt = {PC_HIGH_LATCH_IN[mccd_pkg::PCH_HI:mccd_pkg::PCH_LO],
                          imm};

  always_comb begin
    pc_d = pc_q;
    w_d = w_q;
    z_d = z_q;
    tmo_d = tmo_q;
    pdn_d = pdn_q;
    // the watchdog free-runs outside this block's scope; hold here
    wdog_d = wdog_q;
    pre_d = pre_q;
    ret_d = ret_q;
    push_d = 1'b0;
    fwe_d = 1'b0;
    fa_d = fa_q;
    fwd_d = fwd_q;
    busy_d = 1'b0;
    if (do_op) begin
      pc_d = pc_inc;
      case (op)
        mccd_pkg::MCCD_OP_WDOG_CLR: begin
          wdog_d = mccd_pkg::WDOG_CLEAR;
          pre_d = mccd_pkg::PRE_CLEAR;
          tmo_d = 1'b1;
          pdn_d = 1'b1;
        end
        mccd_pkg::MCCD_OP_CALL: begin
          // return address is the word after the call, not the target
          ret_d = pc_inc;
          push_d = 1'b1;
          pc_d = call_tgt;
          busy_d = 1'b1;
        end
        mccd_pkg::MCCD_OP_COMPL, mccd_pkg::MCCD_OP_DEC: begin
          z_d = res_zero;
          if (dest) begin
            fwe_d = 1'b1;
            fa_d = faddr;
            fwd_d = alu_res;
          end else begin
            w_d = alu_res;
          end
        end
        mccd_pkg::MCCD_OP_REG_CLR: begin
          fwe_d = 1'b1;
          fa_d = faddr;
          fwd_d = mccd_pkg::ZERO8;
          z_d = 1'b1;
        end
        mccd_pkg::MCCD_OP_ACC_CLR: begin
          w_d = mccd_pkg::ZERO8;
          z_d = 1'b1;
        end
        default: begin
          // words outside this subset only step the program counter
          pc_d = pc_inc;
        end
      endcase
    end
  end

  // ***************************************************
  // state
  // ***************************************************
  // program counter, return address and the call stall
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pc_q <= mccd_pkg::PC_RST;
      ret_q <= mccd_pkg::PC_RST;
      push_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      ret_q <= ret_d;
      push_q <= push_d;
      busy_q <= busy_d;
    end
  end

  // accumulator and zero flag
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      w_q <= mccd_pkg::W_RST;
      z_q <= 1'b0;
    end else begin
      w_q <= w_d;
      z_q <= z_d;
    end
  end

  // file register write port; the strobe is a one-cycle pulse
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fwe_q <= 1'b0;
      fa_q <= 7'h00;
      fwd_q <= mccd_pkg::ZERO8;
    end else begin
      fwe_q <= fwe_d;
      fa_q <= fa_d;
      fwd_q <= fwd_d;
    end
  end

  // watchdog clear and the reset status flags
  // nothing here clears the flags: sleep and time-out live elsewhere
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tmo_q <= 1'b1;
      pdn_q <= 1'b1;
      wdog_q <= mccd_pkg::WDOG_CLEAR;
      pre_q <= mccd_pkg::PRE_CLEAR;
    end else begin
      tmo_q <= tmo_d;
      pdn_q <= pdn_d;
      wdog_q <= wdog_d;
      pre_q <= pre_d;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign PC_OUT = pc_q;
  assign STACK_PUSH_OUT = push_q;
  assign RETURN_STACK_TOP_OUT = ret_q;
  assign FREG_ADDR_OUT = fa_q;
  assign FREG_WE_OUT = fwe_q;
  assign FREG_WDATA_OUT = fwd_q;
  assign ACCUM_OUT = w_q;
  assign ZERO_FLAG_OUT = z_q;
  assign TIMEOUT_FLAG_OUT = tmo_q;
  assign POWERDOWN_FLAG_OUT = pdn_q;
  assign WATCHDOG_COUNTER_OUT = wdog_q;
  assign WATCHDOG_PRESCALER_OUT = pre_q;
  assign INSN_READY_OUT = !busy_q;
endmodule

// ===== test/mccd_exec_monitor.sv
// assertion checker for the instruction execution block
`timescale 1ns/1ps
module mccd_exec_monitor (
  // clock, reset and instruction stream
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic INSN_VALID_IN,
  input wire logic [13:0] INSN_IN,
  input wire logic [7:0] FREG_RDATA_IN,
  input wire logic [7:0] PC_HIGH_LATCH_IN,
  // observed results
  input wire logic [12:0] PC_OUT,
  input wire logic STACK_PUSH_OUT,
  input wire logic [12:0] RETURN_STACK_TOP_OUT,
  input wire logic [6:0] FREG_ADDR_OUT,
  input wire logic FREG_WE_OUT,
  input wire logic [7:0] FREG_WDATA_OUT,
  input wire logic [7:0] ACCUM_OUT,
  input wire logic ZERO_FLAG_OUT,
  input wire logic TIMEOUT_FLAG_OUT,
  input wire logic POWERDOWN_FLAG_OUT,
  input wire logic [7:0] WATCHDOG_COUNTER_OUT,
  input wire logic [7:0] WATCHDOG_PRESCALER_OUT,
  input wire logic INSN_READY_OUT
);
  logic [13:0] i_q;
  logic [7:0] r_q;
  logic [7:0] l_q;
  wire tk = INSN_VALID_IN && INSN_READY_OUT;
  wire wd = tk && INSN_IN == 14'h0064;
  wire cl = tk && INSN_IN[13:11] == 3'h4;
  wire cf = tk && INSN_IN[13:8] == 6'h09;
  wire df = tk && INSN_IN[13:8] == 6'h03;
  wire rf = tk && INSN_IN[13:7] == 7'h03;
  wire aw = tk && INSN_IN[13:7] == 7'h02;
  // operands of the word just taken, for the next-cycle checks
  always_ff @(posedge CORE_CLK_IN) begin
    i_q <= INSN_IN;
    r_q <= FREG_RDATA_IN;
    l_q <= PC_HIGH_LATCH_IN;
  end
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence call_s; cl; endsequence
  sequence stall_s; !INSN_READY_OUT ##1 INSN_READY_OUT; endsequence
  wdog_zero_a: assert property (wd |=> WATCHDOG_COUNTER_OUT == 8'h00)
    else $error("watchdog counter not cleared");
  pre_zero_a: assert property (wd |=> WATCHDOG_PRESCALER_OUT == 8'h00)
    else $error("prescaler not cleared");
  wdog_flags_a: assert property (wd |=> TIMEOUT_FLAG_OUT &&
    POWERDOWN_FLAG_OUT) else $error("timeout or powerdown flag not set");
  call_push_a: assert property (call_s |=> STACK_PUSH_OUT &&
    RETURN_STACK_TOP_OUT == $past(PC_OUT) + 13'h0001)
    else $error("wrong return address pushed");
  call_target_a: assert property (call_s |=>
    PC_OUT == {l_q[4:3], i_q[10:0]}) else $error("wrong call target");
  call_stall_a: assert property (call_s |=> stall_s)
    else $error("call did not take two cycles");
  call_flags_a: assert property (call_s |=>
    $stable(ZERO_FLAG_OUT) && $stable(TIMEOUT_FLAG_OUT) &&
    $stable(POWERDOWN_FLAG_OUT)) else $error("call changed a status flag");
  dec_dst_a: assert property (df && INSN_IN[7] |=> FREG_WE_OUT &&
    FREG_WDATA_OUT == r_q - 8'h01 &&
    ZERO_FLAG_OUT == (r_q == 8'h01))
    else $error("decrement to register wrong");
  compl_acc_a: assert property (cf && !INSN_IN[7] |=>
    ACCUM_OUT == ~r_q && ZERO_FLAG_OUT == (r_q == 8'hFF))
    else $error("complement wrong");
  acc_dest_a: assert property ((cf || df) && !INSN_IN[7] |=>
    !FREG_WE_OUT) else $error("register written for accumulator destination");
  clr_reg_a: assert property (rf |=> FREG_WE_OUT &&
    ZERO_FLAG_OUT && FREG_WDATA_OUT == 8'h00 && FREG_ADDR_OUT == i_q[6:0])
    else $error("clear register wrong");
  clr_acc_a: assert property (aw |=> ACCUM_OUT == 8'h00 &&
    ZERO_FLAG_OUT) else $error("clear accumulator wrong");
endmodule
bind mccd_exec mccd_exec_monitor mccd_exec_monitor_inst (.*);

// ===== test/mccd_tb.sv
// self-checking bench for the instruction execution block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic [13:0] ins = 14'h0000;
  logic [7:0] rd = 8'h00;
  logic [7:0] lat = 8'h00;
  wire [12:0] pc, top;
  wire [7:0] wdat, acc, wdc, wdp;
  wire [6:0] adr;
  wire push, we, z, tof, pdf, rdy;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  mccd_exec mccd_exec_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
    .INSN_VALID_IN(vld), .INSN_IN(ins), .FREG_RDATA_IN(rd),
    .PC_HIGH_LATCH_IN(lat), .PC_OUT(pc), .STACK_PUSH_OUT(push),
    .RETURN_STACK_TOP_OUT(top), .FREG_ADDR_OUT(adr), .FREG_WE_OUT(we),
    .FREG_WDATA_OUT(wdat), .ACCUM_OUT(acc), .ZERO_FLAG_OUT(z),
    .TIMEOUT_FLAG_OUT(tof), .POWERDOWN_FLAG_OUT(pdf),
    .WATCHDOG_COUNTER_OUT(wdc), .WATCHDOG_PRESCALER_OUT(wdp),
    .INSN_READY_OUT(rdy));
  initial forever #25 clk = ~clk;
  // ********
  // helpers
  // ********
  task automatic chk(input string n, input logic [23:0] g, e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one word offered for one cycle, results read once they settle
  task automatic op(input logic [13:0] w, input logic [7:0] r);
    @(posedge clk);
    ins <= w;
    rd <= r;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  task automatic t_wdt;
    op(14'h0064, 8'h00);
    chk("wdog", {wdc, wdp}, 16'h0000);
    chk("flags", {tof, pdf}, 2'h3);
  endtask
  task automatic t_dec;
    op(14'h03FF, 8'h01);
    chk("decr", {we, adr, wdat, z}, {1'b1, 7'h7F, 8'h00, 1'b1});
    op(14'h0305, 8'h00);
    chk("deca", {we, acc, z}, {1'b0, 8'hFF, 1'b0});
  endtask
  task automatic t_clr;
    op(14'h0100, 8'h00);
    chk("clra", {acc, z}, {8'h00, 1'b1});
    op(14'h0912, 8'hFF);
    chk("cpla", {we, acc, z}, {1'b0, 8'h00, 1'b1});
    op(14'h09C0, 8'h5A);
    chk("cplr", {we, adr, wdat, z}, {1'b1, 7'h40, 8'hA5, 1'b0});
    op(14'h01AA, 8'h77);
    chk("clrr", {we, adr, wdat, z}, {1'b1, 7'h2A, 8'h00, 1'b1});
  endtask
  // a word offered in the second call cycle must be ignored
  task automatic t_call;
    logic [12:0] p;
    p = pc;
    @(posedge clk);
    ins <= 14'h27FF;
    lat <= 8'hF7;
    vld <= 1'b1;
    @(posedge clk);
    ins <= 14'h0301;
    rd <= 8'h10;
    #1;
    chk("call", {push, pc, rdy, z}, {1'b1, 13'h17FF, 2'h1});
    chk("top", top, 13'(p + 13'h0001));
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk("stall", {push, rdy, pc, acc}, {2'h1, 13'h17FF, 8'h00});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_wdt();
    t_dec();
    t_clr();
    t_call();
    end_of_test();
  end
endmodule
